// ### logic/panel_check_defines.svh
// Offsets, field positions, reset values and counts of the panel check block
`ifndef PANEL_CHECK_DEFINES_SVH
`define PANEL_CHECK_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define PCK_OFS_PARAM     5'h00
`define PCK_OFS_STATUS    5'h04
`define PCK_OFS_EVENT     5'h08
`define PCK_OFS_MASK      5'h0C
`define PCK_OFS_COMMAND   5'h10

// ----------------------------------------------------------------------
// Parameter register fields and reset values
// ----------------------------------------------------------------------
`define PCK_PARAM_RELAX_BIT    0
`define PCK_PARAM_EXPECT_BIT   1
`define PCK_RELAX_RESET        1'h1
`define PCK_EXPECT_RESET       1'h1

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define PCK_STAT_ALLOWED_BIT   0
`define PCK_STAT_FAULT_BIT     1
`define PCK_STAT_DIAG_BIT      2
`define PCK_STAT_PANEL_BIT     3
`define PCK_STAT_TRIPPED_BIT   4
`define PCK_STAT_RUN_BIT       5

// ----------------------------------------------------------------------
// Event register fields (mask has the same layout)
// ----------------------------------------------------------------------
`define PCK_EVT_WIDTH          4
`define PCK_EVT_MISMATCH_BIT   0
`define PCK_EVT_TRIP_BIT       1
`define PCK_EVT_AUTOCLR_BIT    2
`define PCK_EVT_MODULE_BIT     3
`define PCK_EVT_RESET          4'h0
`define PCK_MASK_RESET         4'h0

// ----------------------------------------------------------------------
// Command register fields
// ----------------------------------------------------------------------
`define PCK_CMD_TRIP_RESET_BIT 0

// ----------------------------------------------------------------------
// Presence sampling depth in clock cycles
// ----------------------------------------------------------------------
`define PCK_SYNC_STAGES        2

`endif

// ### logic/panel_check_pkg.sv
// Types shared by the panel check block
package panel_check_pkg;

    // Operating state of the relay
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_TRIPPED
    } op_state_t;

endpackage : panel_check_pkg

// ### logic/panel_config_check.sv
// Operator panel configuration check with Avalon-MM register access
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none

`include "panel_check_defines.svh"

module panel_config_check
    import panel_check_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        sys_rst_i,
    // Avalon-MM slave
    input  wire logic [4:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    // Device status inputs
    input  wire logic        panel_present_i,
    input  wire logic        module_comm_bad_i,
    input  wire logic        module_wrong_i,
    input  wire logic        run_cmd_i,
    // Device outputs
    output logic             operation_allowed_o,
    output logic             contactor_on_o,
    output logic             group_fault_o,
    output logic             config_mismatch_o,
    output logic             irq_o
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    presence_if                   pres ();        // Sampled status bundle
    logic                         relax;          // Strictness parameter
    logic                         panel_expected; // Panel preset
    op_state_t                    state;          // Operating state
    op_state_t                    next_state;     // Next operating state
    logic                         cause_unexp;    // Trip from unexpected panel
    logic                         ack;            // Bus answer cycle
    logic                         bus_access;     // Request pending
    logic                         wr_en;          // Write takes effect
    logic                         enf_mismatch;   // Enforced mismatch now
    logic                         enf_mismatch_q; // Previous enforced mismatch
    logic                         module_bad;     // Any module fault
    logic                         module_bad_q;   // Previous module fault
    logic                         trip_reset;     // Trip acknowledge pulse
    logic                         auto_clear;     // Automatic fault clear
    logic [`PCK_EVT_WIDTH-1:0]    evt_status;     // Sticky events
    logic [`PCK_EVT_WIDTH-1:0]    evt_mask;       // Event enables
    logic [`PCK_EVT_WIDTH-1:0]    evt_set;        // Event pulses
    logic [`PCK_EVT_WIDTH-1:0]    evt_clr;        // Write-one-to-clear
    logic [31:0]                  next_rdata;     // Read mux

    // ------------------------------------------------------------------
    // Presence sampling
    // ------------------------------------------------------------------
    // Sampled presence gives a fixed compare latency
    presence_sampler u_sampler (
        .sys_clk_i         (sys_clk_i),
        .sys_rst_i         (sys_rst_i),
        .panel_present_i   (panel_present_i),
        .module_comm_bad_i (module_comm_bad_i),
        .module_wrong_i    (module_wrong_i),
        .smp               (pres.sampler)
    );

    // ------------------------------------------------------------------
    // Avalon-MM slave timing
    // ------------------------------------------------------------------
    // One wait state: answer on the second edge of a request
    assign bus_access        = avs_read_i | avs_write_i;
    assign avs_waitrequest_o = bus_access & ~ack;
    assign wr_en             = avs_write_i & ack & avs_byteenable_i[0];

    // Answer flag, high for one cycle per request
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ack <= 1'b0;
        end else begin
            ack <= bus_access & ~ack;
        end
    end

    // ------------------------------------------------------------------
    // Parameters, written only over the register bus
    // ------------------------------------------------------------------
    // Strictness and preset; no local control reaches them
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            relax          <= `PCK_RELAX_RESET;
            panel_expected <= `PCK_EXPECT_RESET;
        end else if (wr_en && avs_address_i == `PCK_OFS_PARAM) begin
            relax          <= avs_writedata_i[`PCK_PARAM_RELAX_BIT];
            panel_expected <= avs_writedata_i[`PCK_PARAM_EXPECT_BIT];
        end
    end

    // Trip acknowledge from the command register
    assign trip_reset = wr_en && avs_address_i == `PCK_OFS_COMMAND
                        && avs_writedata_i[`PCK_CMD_TRIP_RESET_BIT];

    // ------------------------------------------------------------------
    // Configuration compare
    // ------------------------------------------------------------------
    // Mismatch only counts while the check is enforced
    assign enf_mismatch = ~relax & (pres.panel_present != panel_expected);
    assign module_bad   = pres.module_comm_bad | pres.module_wrong;

    // Unexpected panel gone while tripped for it
    assign auto_clear = (state == ST_TRIPPED) && cause_unexp
                        && !pres.panel_present && !panel_expected;

    // ------------------------------------------------------------------
    // Operating state machine
    // ------------------------------------------------------------------
    // Next state from command, compare and acknowledges
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (enf_mismatch && pres.panel_present) begin
                    next_state = ST_TRIPPED;
                end else if (run_cmd_i && !enf_mismatch) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (enf_mismatch) begin
                    next_state = ST_TRIPPED;
                end else if (!run_cmd_i) begin
                    next_state = ST_IDLE;
                end
            end
            ST_TRIPPED: begin
                if (relax || auto_clear) begin
                    next_state = ST_IDLE;
                end else if (trip_reset && !enf_mismatch) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Remember whether the trip came from an unexpected panel
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cause_unexp <= 1'b0;
        end else if (state != ST_TRIPPED && next_state == ST_TRIPPED) begin
            cause_unexp <= pres.panel_present & ~panel_expected;
        end
    end

    // ------------------------------------------------------------------
    // Device outputs
    // ------------------------------------------------------------------
    // Operation blocked while tripped or mismatched
    assign operation_allowed_o = (state != ST_TRIPPED) && !enf_mismatch;
    assign contactor_on_o      = (state == ST_RUN);
    // Group fault on trip or on any enforced mismatch
    assign group_fault_o       = (state == ST_TRIPPED) || enf_mismatch;
    // Diagnostic from the panel check or from the current module
    assign config_mismatch_o   = enf_mismatch || (state == ST_TRIPPED)
                                 || module_bad;

    // ------------------------------------------------------------------
    // Events and interrupt
    // ------------------------------------------------------------------
    // Edge history for event pulses
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            enf_mismatch_q <= 1'b0;
            module_bad_q   <= 1'b0;
        end else begin
            enf_mismatch_q <= enf_mismatch;
            module_bad_q   <= module_bad;
        end
    end

    // Event pulses in register layout
    always_comb begin
        evt_set = '0;
        evt_set[`PCK_EVT_MISMATCH_BIT] = enf_mismatch & ~enf_mismatch_q;
        evt_set[`PCK_EVT_TRIP_BIT]     = (state != ST_TRIPPED) && (next_state == ST_TRIPPED);
        evt_set[`PCK_EVT_AUTOCLR_BIT]  = auto_clear & ~relax;
        evt_set[`PCK_EVT_MODULE_BIT]   = module_bad & ~module_bad_q;
    end

    // Write-one-to-clear mask of the event register
    assign evt_clr = (wr_en && avs_address_i == `PCK_OFS_EVENT)
                     ? avs_writedata_i[`PCK_EVT_WIDTH-1:0] : '0;

    // Sticky events; a new event wins over its clear
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            evt_status <= `PCK_EVT_RESET;
        end else begin
            evt_status <= (evt_status & ~evt_clr) | evt_set;
        end
    end

    // Event enables
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            evt_mask <= `PCK_MASK_RESET;
        end else if (wr_en && avs_address_i == `PCK_OFS_MASK) begin
            evt_mask <= avs_writedata_i[`PCK_EVT_WIDTH-1:0];
        end
    end

    // Level interrupt while any enabled event stands
    assign irq_o = |(evt_status & evt_mask);

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Register select; unmapped offsets read zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (avs_address_i)
            `PCK_OFS_PARAM: begin
                next_rdata[`PCK_PARAM_RELAX_BIT]  = relax;
                next_rdata[`PCK_PARAM_EXPECT_BIT] = panel_expected;
            end
            `PCK_OFS_STATUS: begin
                next_rdata[`PCK_STAT_ALLOWED_BIT] = operation_allowed_o;
                next_rdata[`PCK_STAT_FAULT_BIT]   = group_fault_o;
                next_rdata[`PCK_STAT_DIAG_BIT]    = config_mismatch_o;
                next_rdata[`PCK_STAT_PANEL_BIT]   = pres.panel_present;
                next_rdata[`PCK_STAT_TRIPPED_BIT] = (state == ST_TRIPPED);
                next_rdata[`PCK_STAT_RUN_BIT]     = (state == ST_RUN);
            end
            `PCK_OFS_EVENT: begin
                next_rdata[`PCK_EVT_WIDTH-1:0] = evt_status;
            end
            `PCK_OFS_MASK: begin
                next_rdata[`PCK_EVT_WIDTH-1:0] = evt_mask;
            end
            default: begin
                next_rdata = 32'h0000_0000;
            end
        endcase
    end

    // Read data captured on the wait cycle, stands at the answer edge
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i && !ack) begin
            avs_readdata_o <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    // Relaxed check never faults nor blocks outside a trip
    relax_allows_a: assert property (
        relax && state != ST_TRIPPED |-> operation_allowed_o && !group_fault_o)
        else $error("relaxed check blocked operation");

    // Enforced operation only with matching presence
    enforce_match_a: assert property (
        operation_allowed_o && !relax |-> pres.panel_present == panel_expected)
        else $error("operation allowed on mismatch");

    // Enforced mismatch shows on the diagnostic
    mismatch_diag_a: assert property (
        !relax && pres.panel_present != panel_expected |-> config_mismatch_o)
        else $error("mismatch diagnostic missing");

    // Missing expected panel stops a start
    start_refused_a: assert property (
        state == ST_IDLE && !relax && panel_expected && !pres.panel_present && run_cmd_i
        |=> state != ST_RUN)
        else $error("start not refused");

    // Expected panel lost while running trips next cycle
    run_trip_a: assert property (
        state == ST_RUN && !relax && panel_expected && !pres.panel_present
        |=> state == ST_TRIPPED && group_fault_o)
        else $error("no trip on lost panel");

    // Unexpected panel removed clears the trip next cycle
    auto_clear_a: assert property (
        state == ST_TRIPPED && cause_unexp && !pres.panel_present && !panel_expected
        |=> state == ST_IDLE ##1 !group_fault_o || pres.panel_present != panel_expected)
        else $error("trip not auto cleared");

    // Parameters change only on a bus write
    param_write_a: assert property (
        !$stable(relax) || !$stable(panel_expected)
        |-> $past(wr_en) && $past(avs_address_i) == `PCK_OFS_PARAM)
        else $error("parameter changed without write");

    // Module faults raise the diagnostic in any mode
    module_diag_a: assert property (
        pres.module_comm_bad || pres.module_wrong |-> config_mismatch_o)
        else $error("module fault not reported");

    // Tripped relay always shows the group fault
    trip_fault_a: assert property (
        state == ST_TRIPPED |-> group_fault_o && !operation_allowed_o)
        else $error("trip without group fault");

    // Sampled presence trails the pin by a fixed latency
    sample_delay_a: assert property (
        $stable(panel_present_i)[*3] |-> pres.panel_present == panel_present_i)
        else $error("presence latency wrong");

    // Main scenarios
    cover_trip_c: cover property (state == ST_RUN ##1 state == ST_TRIPPED);
    cover_auto_c: cover property (auto_clear && !relax);
    cover_irq_c:  cover property ($rose(irq_o));
    cover_reset_c: cover property (state == ST_TRIPPED && trip_reset && !enf_mismatch);

endmodule : panel_config_check

`default_nettype wire

// ### logic/presence_if.sv
// Sampled panel and current-module status between sampler and checker
`timescale 1ns/100ps
`default_nettype none

interface presence_if;
    logic panel_present;   // Sampled panel presence
    logic module_comm_bad; // Sampled current-module link fault
    logic module_wrong;    // Sampled wrong current module

    // Sampler drives, compare logic reads
    modport sampler (output panel_present, output module_comm_bad, output module_wrong);
    modport watcher (input panel_present, input module_comm_bad, input module_wrong);
endinterface : presence_if

`default_nettype wire

// ### logic/presence_sampler.sv
// Fixed-depth sampler for panel presence and current-module status
`timescale 1ns/100ps
`default_nettype none

`include "panel_check_defines.svh"

module presence_sampler (
    // Clock and reset
    input  wire logic  sys_clk_i,
    input  wire logic  sys_rst_i,
    // Raw status inputs
    input  wire logic  panel_present_i,
    input  wire logic  module_comm_bad_i,
    input  wire logic  module_wrong_i,
    // Sampled status
    presence_if.sampler smp
);

    // ------------------------------------------------------------------
    // Sampling chain
    // ------------------------------------------------------------------
    logic [`PCK_SYNC_STAGES-1:0] panel_chain;   // Presence stages
    logic [1:0]                  module_stage;  // Module status stage

    // Shift presence through a fixed number of stages
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            panel_chain <= '0;
        end else begin
            panel_chain <= {panel_chain[`PCK_SYNC_STAGES-2:0], panel_present_i};
        end
    end

    // Register module status once
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            module_stage <= 2'h0;
        end else begin
            module_stage <= {module_wrong_i, module_comm_bad_i};
        end
    end

    // Last stage only leaves the sampler
    assign smp.panel_present   = panel_chain[`PCK_SYNC_STAGES-1];
    assign smp.module_comm_bad = module_stage[0];
    assign smp.module_wrong    = module_stage[1];

endmodule : presence_sampler

`default_nettype wire

// ### verification/panel_config_check_tb_top.sv
// Self-checking bench of the panel configuration check
`timescale 1ns/100ps
`default_nettype none

module panel_config_check_tb_top;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        clk = 1'b0;      // 40 MHz clock
    logic        rst = 1'b1;      // Active high reset
    logic [4:0]  addr = 5'h00;    // Bus address
    logic        rd = 1'b0;       // Bus read
    logic        wr = 1'b0;       // Bus write
    logic [31:0] wdata = 32'h0;   // Bus write data
    logic [31:0] rdata;           // Bus read data
    logic        wreq;            // Wait request
    logic        plug = 1'b0;     // Panel plugged
    logic        pres;            // Panel presence contact
    logic        cbad = 1'b0;     // Module link fault
    logic        mwrong = 1'b0;   // Wrong module
    logic        run = 1'b0;      // ON command
    logic [4:0]  outs;            // Allowed, on, fault, diag, irq
    int          miscompares = 0; // Mismatch count
    int          comparisons = 0; // Comparison count

    always #12.5 clk = ~clk;

    panel_model i_panel_model (.sys_clk_i(clk), .plug_i(plug), .panel_present_o(pres));

    panel_config_check i_panel_config_check (
        .sys_clk_i(clk), .sys_rst_i(rst), .avs_address_i(addr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(4'hF),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .panel_present_i(pres),
        .module_comm_bad_i(cbad), .module_wrong_i(mwrong), .run_cmd_i(run),
        .operation_allowed_o(outs[4]), .contactor_on_o(outs[3]),
        .group_fault_o(outs[2]), .config_mismatch_o(outs[1]), .irq_o(outs[0]));

    // ------------------------------------------------------------
    // Helper tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    // One bus cycle, entered and left just after a rising edge
    // Wait request and read data are read at the edge, before it updates them
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        addr  <= a;
        wdata <= d;
        rd    <= ~w;
        wr    <= w;
        @(posedge clk);
        while (wreq !== 1'b0) begin
            @(posedge clk);
        end
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic wreg(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wreg

    task automatic rchk(input string nm, input logic [4:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(nm, q, e);
    endtask : rchk

    // Let sampling and state settle, then compare all outputs
    task automatic pchk(input logic [4:0] e);
        repeat (5) @(posedge clk);
        @(negedge clk);
        chk("outputs", {27'h0, outs}, {27'h0, e});
        @(posedge clk);
    endtask : pchk

    task automatic stop_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rchk("param", 5'h00, 32'h3);
        rchk("mask", 5'h0C, 32'h0);
        rchk("event", 5'h08, 32'h0);
        rchk("unmapped", 5'h14, 32'h0);
        wreg(5'h14, 32'h0);
        rchk("param", 5'h00, 32'h3);
        pchk(5'b10000);
        $display("test reset done");
    endtask : t_reset

    task automatic t_relax;
        run <= 1'b1;
        pchk(5'b11000);
        plug <= 1'b1;
        pchk(5'b11000);
        plug <= 1'b0;
        pchk(5'b11000);
        run <= 1'b0;
        pchk(5'b10000);
        $display("test relax done");
    endtask : t_relax

    task automatic t_expect;
        wreg(5'h00, 32'h2);
        run <= 1'b1;
        pchk(5'b00110);
        rchk("status", 5'h04, 32'h06);
        wreg(5'h08, 32'hF);
        plug <= 1'b1;
        pchk(5'b11000);
        wreg(5'h0C, 32'h2);
        plug <= 1'b0;
        pchk(5'b00111);
        rchk("status", 5'h04, 32'h16);
        rchk("event", 5'h08, 32'h3);
        wreg(5'h08, 32'h2);
        plug <= 1'b1;
        pchk(5'b00110);
        run <= 1'b0;
        wreg(5'h10, 32'h1);
        pchk(5'b10000);
        $display("test expected panel done");
    endtask : t_expect

    task automatic t_noexp;
        wreg(5'h08, 32'hF);
        wreg(5'h00, 32'h0);
        pchk(5'b00111);
        rchk("status", 5'h04, 32'h1E);
        wreg(5'h08, 32'hF);
        plug <= 1'b0;
        pchk(5'b10000);
        rchk("status", 5'h04, 32'h01);
        rchk("event", 5'h08, 32'h4);
        $display("test no panel expected done");
    endtask : t_noexp

    task automatic t_module;
        wreg(5'h00, 32'h3);
        wreg(5'h08, 32'hF);
        mwrong <= 1'b1;
        pchk(5'b10010);
        rchk("event", 5'h08, 32'h8);
        mwrong <= 1'b0;
        cbad   <= 1'b1;
        pchk(5'b10010);
        cbad <= 1'b0;
        pchk(5'b10000);
        $display("test module faults done");
    endtask : t_module

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_relax();
        t_expect();
        t_noexp();
        t_module();
        stop_test();
    end

    initial begin
        repeat (6000) @(posedge clk);
        miscompares++;
        stop_test();
    end
endmodule : panel_config_check_tb_top

`default_nettype wire

// ### verification/panel_model.sv
// Operator panel model: presence contact of a pluggable panel
`timescale 1ns/100ps
`default_nettype none

module panel_model (
    // Clock
    input  wire logic sys_clk_i,
    // Plug control from the bench
    input  wire logic plug_i,
    // Presence contact toward the device
    output logic      panel_present_o = 1'b0
);
    // ------------------------------------------------------------
    // Presence contact
    // ------------------------------------------------------------
    // Contact follows plugging one edge later; no path alters parameters
    always @(posedge sys_clk_i) begin
        panel_present_o <= plug_i;
    end
endmodule : panel_model

`default_nettype wire
